// [rtl/cbf_exec.sv]
// Execution unit for conditional branches, I/O bit ops, shifts and flag ops.
// Assumes one op is presented per accepted cycle while busy is low.
`timescale 1ns/1ps

// Functional notes
// - Carry set branch jumps to pc plus offset plus one; no flags.
// - Negative branch on N one, positive branch on N zero.
// - Signed ge taken on N xor V zero, signed lt on one.
// - Half carry set and clear branches test H.
// - Transfer bit set branch jumps when T is one.
// - Interrupt enabled and disabled branches test I.
// - I/O bit set forces the chosen bit one in two cycles.
// - I/O bit clear forces the chosen bit zero in two cycles.
// - Left shift inserts zero at bit 0, updates Z C N V.
// - Right shift inserts zero at bit 7, updates Z C N V.
// - Rotate left takes carry into bit 0, carry from bit 7.
// - Rotate right takes carry into bit 7, carry from bit 0.
// - Nibble swap exchanges halves, flags unchanged, one cycle.
// - Bit to transfer copies a register bit into T only.
// - Transfer to bit writes T into a register bit.
// - Flag set or clear changes only the named flag.
// - Carry clear and same or higher branch when carry is zero.
module cbf_exec (
    input  wire logic            ref_clk,   // Core clock, 10 MHz.
    input  wire logic            resetn,    // Synchronous reset, active low.
    input  wire cbf_pkg::cbf_op_e op,       // Operation, sampled when not busy.
    input  wire logic [6:0]      offset,    // Signed branch displacement.
    input  wire logic [4:0]      reg_sel,   // Working register index.
    input  wire logic [4:0]      io_sel,    // I/O register index.
    input  wire logic [2:0]      bit_sel,   // Bit or flag index.
    output logic      [15:0]     pc_ff,     // Program counter.
    output logic      [7:0]      status_ff, // Status flags.
    output logic                 busy_ff,   // Second cycle of a two-cycle op.
    output logic      [7:0]      io_rd_ff,  // Selected I/O register, registered.
    output logic      [7:0]      reg_rd_ff  // Selected working register, registered.
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0]  regs_ff [cbf_pkg::NUM_REGS];
    logic [7:0]  io_ff   [cbf_pkg::NUM_IO];
    logic [7:0]  nxt_reg_val;
    logic        reg_we;
    logic [7:0]  nxt_io_val;
    logic        io_we;
    logic [15:0] nxt_pc;
    logic [7:0]  nxt_status;
    logic        nxt_busy;
    logic [15:0] hold_pc_ff;
    logic [15:0] nxt_hold_pc;
    logic        cond;
    logic        is_branch;
    logic [7:0]  sh_res;
    logic [7:0]  sh_swap;
    logic        sh_c;
    logic        sh_z;
    logic        sh_n;
    logic        sh_v;
    logic [15:0] target;
    logic [7:0]  cur_reg;
    logic [7:0]  cur_io;
    logic [1:0]  sh_kind;

    assign cur_reg = regs_ff[reg_sel];
    assign cur_io  = io_ff[io_sel];
    // Offset is sign-extended, so backward branches wrap correctly.
    assign target  = pc_ff + {{9{offset[6]}}, offset} + 16'h0001;
    // Shift codes are consecutive, so the distance from the left shift
    // picks the form; the low op bits alone would give lsl 3, lsr 0, rol 1 and ror 2.
    assign sh_kind = 2'(op - cbf_pkg::CBF_LOGICAL_LEFT_SHIFT);

    cbf_shift_unit u_shift (
        .operand   (cur_reg),
        .carry_in  (status_ff[cbf_pkg::FLAG_C]),
        .kind      (sh_kind),
        .result    (sh_res),
        .carry_out (sh_c),
        .zero_out  (sh_z),
        .neg_out   (sh_n),
        .ovf_out   (sh_v),
        .swapped   (sh_swap)
    );

    // ****************************************************************
    // Branch condition
    // ****************************************************************
    // Each branch form reads exactly one flag or the N xor V pair.
    always_comb begin
        is_branch = 1'b1;
        unique case (op)
            cbf_pkg::CBF_BRANCH_ON_CARRY_SET:     cond = status_ff[cbf_pkg::FLAG_C];
            cbf_pkg::CBF_BRANCH_SAME_OR_HIGHER,
            cbf_pkg::CBF_BRANCH_ON_CARRY_CLEAR:   cond = !status_ff[cbf_pkg::FLAG_C];
            cbf_pkg::CBF_BRANCH_ON_NEGATIVE:      cond = status_ff[cbf_pkg::FLAG_N];
            cbf_pkg::CBF_BRANCH_ON_POSITIVE:      cond = !status_ff[cbf_pkg::FLAG_N];
            cbf_pkg::CBF_BRANCH_SIGNED_GE:        cond = !(status_ff[cbf_pkg::FLAG_N]
                                                        ^ status_ff[cbf_pkg::FLAG_V]);
            cbf_pkg::CBF_BRANCH_SIGNED_LT:        cond = status_ff[cbf_pkg::FLAG_N]
                                                        ^ status_ff[cbf_pkg::FLAG_V];
            cbf_pkg::CBF_BRANCH_HALF_CARRY_SET:   cond = status_ff[cbf_pkg::FLAG_H];
            cbf_pkg::CBF_BRANCH_HALF_CARRY_CLEAR: cond = !status_ff[cbf_pkg::FLAG_H];
            cbf_pkg::CBF_BRANCH_TRANSFER_BIT_SET: cond = status_ff[cbf_pkg::FLAG_T];
            cbf_pkg::CBF_BRANCH_IRQ_ENABLED:      cond = status_ff[cbf_pkg::FLAG_I];
            cbf_pkg::CBF_BRANCH_IRQ_DISABLED:     cond = !status_ff[cbf_pkg::FLAG_I];
            default: begin
                cond      = 1'b0;
                is_branch = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Two-cycle ops park the final pc in hold_pc_ff and commit it on the
    // second cycle, so pc never shows a half-finished value.
    always_comb begin
        nxt_pc      = pc_ff;
        nxt_status  = status_ff;
        nxt_busy    = 1'b0;
        nxt_hold_pc = hold_pc_ff;
        nxt_reg_val = cur_reg;
        reg_we      = 1'b0;
        nxt_io_val  = cur_io;
        io_we       = 1'b0;
        if (busy_ff) begin
            nxt_pc = hold_pc_ff;
        end else if (is_branch) begin
            if (cond) begin
                nxt_busy    = 1'b1;
                nxt_hold_pc = target;
            end else begin
                nxt_pc = pc_ff + 16'h0001;
            end
        end else begin
            nxt_pc = pc_ff + 16'h0001;
            unique case (op)
                cbf_pkg::CBF_IO_BIT_SET, cbf_pkg::CBF_IO_BIT_CLEAR: begin
                    nxt_io_val[bit_sel] = (op == cbf_pkg::CBF_IO_BIT_SET);
                    io_we       = 1'b1;
                    nxt_busy    = 1'b1;
                    nxt_hold_pc = pc_ff + 16'h0001;
                    nxt_pc      = pc_ff;
                end
                cbf_pkg::CBF_LOGICAL_LEFT_SHIFT, cbf_pkg::CBF_LOGICAL_RIGHT_SHIFT,
                cbf_pkg::CBF_ROTATE_LEFT_CARRY, cbf_pkg::CBF_ROTATE_RIGHT_CARRY: begin
                    nxt_reg_val = sh_res;
                    reg_we      = 1'b1;
                    nxt_status[cbf_pkg::FLAG_C] = sh_c;
                    nxt_status[cbf_pkg::FLAG_Z] = sh_z;
                    nxt_status[cbf_pkg::FLAG_N] = sh_n;
                    nxt_status[cbf_pkg::FLAG_V] = sh_v;
                end
                cbf_pkg::CBF_NIBBLE_SWAP: begin
                    nxt_reg_val = sh_swap;
                    reg_we      = 1'b1;
                end
                cbf_pkg::CBF_BIT_TO_TRANSFER: begin
                    nxt_status[cbf_pkg::FLAG_T] = cur_reg[bit_sel];
                end
                cbf_pkg::CBF_TRANSFER_TO_BIT: begin
                    nxt_reg_val[bit_sel] = status_ff[cbf_pkg::FLAG_T];
                    reg_we = 1'b1;
                end
                cbf_pkg::CBF_STATUS_BIT_FORCE_ONE:  nxt_status[bit_sel] = 1'b1;
                cbf_pkg::CBF_STATUS_BIT_FORCE_ZERO: nxt_status[bit_sel] = 1'b0;
                default: nxt_pc = pc_ff + 16'h0001;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pc_ff      <= cbf_pkg::PC_RST;
            status_ff  <= cbf_pkg::STATUS_RST;
            busy_ff    <= 1'b0;
            hold_pc_ff <= cbf_pkg::PC_RST;
            io_rd_ff   <= cbf_pkg::IO_RST;
            reg_rd_ff  <= cbf_pkg::REG_RST;
            for (int i = 0; i < cbf_pkg::NUM_REGS; i++) begin
                regs_ff[i] <= cbf_pkg::REG_RST;
            end
            for (int i = 0; i < cbf_pkg::NUM_IO; i++) begin
                io_ff[i] <= cbf_pkg::IO_RST;
            end
        end else begin
            pc_ff      <= nxt_pc;
            status_ff  <= nxt_status;
            busy_ff    <= nxt_busy;
            hold_pc_ff <= nxt_hold_pc;
            io_rd_ff   <= io_we ? nxt_io_val : cur_io;
            reg_rd_ff  <= reg_we ? nxt_reg_val : cur_reg;
            if (reg_we) begin
                regs_ff[reg_sel] <= nxt_reg_val;
            end
            if (io_we) begin
                io_ff[io_sel] <= nxt_io_val;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_taken;
        !busy_ff && is_branch && cond;
    endsequence

    a_taken_target: assert property (s_taken |=> busy_ff ##1 (pc_ff == $past(target, 2)))
        else $error("taken branch target wrong");
    a_untaken_step: assert property (!busy_ff && is_branch && !cond
        |=> !busy_ff && pc_ff == $past(pc_ff) + 16'h0001)
        else $error("untaken branch not one cycle");
    a_branch_flags: assert property (!busy_ff && is_branch |=> $stable(status_ff))
        else $error("branch altered flags");
    a_signed_ge: assert property (!busy_ff && op == cbf_pkg::CBF_BRANCH_SIGNED_GE
        |-> cond == (status_ff[cbf_pkg::FLAG_N] == status_ff[cbf_pkg::FLAG_V]))
        else $error("signed ge condition wrong");
    a_io_two_cyc: assert property (!busy_ff && op == cbf_pkg::CBF_IO_BIT_SET
        |=> busy_ff && io_rd_ff[$past(bit_sel)] ##1 !busy_ff)
        else $error("io bit set wrong");
    a_io_clear: assert property (!busy_ff && op == cbf_pkg::CBF_IO_BIT_CLEAR
        |=> !io_rd_ff[$past(bit_sel)] && $stable(status_ff))
        else $error("io bit clear wrong");
    a_lsl_value: assert property (!busy_ff && op == cbf_pkg::CBF_LOGICAL_LEFT_SHIFT
        |=> reg_rd_ff == {$past(cur_reg[6:0]), 1'b0}
            && status_ff[cbf_pkg::FLAG_C] == $past(cur_reg[7]))
        else $error("left shift wrong");
    a_ror_value: assert property (!busy_ff && op == cbf_pkg::CBF_ROTATE_RIGHT_CARRY
        |=> reg_rd_ff == {$past(status_ff[cbf_pkg::FLAG_C]), $past(cur_reg[7:1])})
        else $error("rotate right wrong");
    a_swap_flags: assert property (!busy_ff && op == cbf_pkg::CBF_NIBBLE_SWAP
        |=> $stable(status_ff) && reg_rd_ff == {$past(cur_reg[3:0]), $past(cur_reg[7:4])})
        else $error("swap wrong");
    a_bst_copy: assert property (!busy_ff && op == cbf_pkg::CBF_BIT_TO_TRANSFER
        |=> status_ff[cbf_pkg::FLAG_T] == $past(cur_reg[bit_sel]))
        else $error("bit to transfer wrong");
    a_flag_force: assert property (!busy_ff && op == cbf_pkg::CBF_STATUS_BIT_FORCE_ONE
        |=> status_ff[$past(bit_sel)])
        else $error("flag set wrong");

endmodule

// [shared/cbf_pkg.sv]
// Constants and types for the branch, bit and flag execution unit.
// Assumes a single core clock and an 8-bit status register held here.
package cbf_pkg;

    // ****************************************************************
    // Status flag positions (layout chosen for this unit)
    // ****************************************************************
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;

    // ****************************************************************
    // Reset values and widths
    // ****************************************************************
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [15:0] PC_RST     = 16'h0000;
    localparam logic [7:0]  IO_RST     = 8'h00;
    localparam logic [7:0]  REG_RST    = 8'h00;
    localparam int unsigned NUM_REGS   = 32;
    localparam int unsigned NUM_IO     = 32;

    // ****************************************************************
    // Operations presented on the op port
    // ****************************************************************
    typedef enum logic [5:0] {
        CBF_NOP,
        CBF_BRANCH_ON_CARRY_SET,
        CBF_BRANCH_SAME_OR_HIGHER,
        CBF_BRANCH_ON_CARRY_CLEAR,
        CBF_BRANCH_ON_NEGATIVE,
        CBF_BRANCH_ON_POSITIVE,
        CBF_BRANCH_SIGNED_GE,
        CBF_BRANCH_SIGNED_LT,
        CBF_BRANCH_HALF_CARRY_SET,
        CBF_BRANCH_HALF_CARRY_CLEAR,
        CBF_BRANCH_TRANSFER_BIT_SET,
        CBF_BRANCH_IRQ_ENABLED,
        CBF_BRANCH_IRQ_DISABLED,
        CBF_IO_BIT_SET,
        CBF_IO_BIT_CLEAR,
        CBF_LOGICAL_LEFT_SHIFT,
        CBF_LOGICAL_RIGHT_SHIFT,
        CBF_ROTATE_LEFT_CARRY,
        CBF_ROTATE_RIGHT_CARRY,
        CBF_NIBBLE_SWAP,
        CBF_BIT_TO_TRANSFER,
        CBF_TRANSFER_TO_BIT,
        CBF_STATUS_BIT_FORCE_ONE,
        CBF_STATUS_BIT_FORCE_ZERO
    } cbf_op_e;

endpackage

// [rtl/cbf_shift_unit.sv]
// Combinational shift, rotate and swap data path with flag results.
// Assumes the caller selects which result and flags are committed.
`timescale 1ns/1ps
module cbf_shift_unit (
    input  wire logic [7:0] operand,  // Register value to transform.
    input  wire logic       carry_in, // Current carry flag.
    input  wire logic [1:0] kind,     // 0 lsl, 1 lsr, 2 rol, 3 ror.
    output logic      [7:0] result,   // Shifted value.
    output logic            carry_out,// New carry flag.
    output logic            zero_out, // New zero flag.
    output logic            neg_out,  // New negative flag.
    output logic            ovf_out,  // New overflow flag (N xor C).
    output logic      [7:0] swapped   // Nibble-exchanged value.
);

    // ****************************************************************
    // Shift selection
    // ****************************************************************
    // Left forms take carry from bit 7, right forms from bit 0.
    always_comb begin
        unique case (kind)
            2'd0: begin
                result    = {operand[6:0], 1'b0};
                carry_out = operand[7];
            end
            2'd1: begin
                result    = {1'b0, operand[7:1]};
                carry_out = operand[0];
            end
            2'd2: begin
                result    = {operand[6:0], carry_in};
                carry_out = operand[7];
            end
            default: begin
                result    = {carry_in, operand[7:1]};
                carry_out = operand[0];
            end
        endcase
    end

    // Flags follow the stored result; overflow is N xor C as usual.
    assign zero_out = (result == 8'h00);
    assign neg_out  = result[7];
    assign ovf_out  = result[7] ^ carry_out;
    assign swapped  = {operand[3:0], operand[7:4]};

endmodule

// [dv/cpu_branch_bit_flag_ops_tb.sv]
// Self-checking bench for the branch, bit and flag execution unit.
// Assumes cbf_pkg is compiled first; every op is followed by a NOP.
`timescale 1ns/1ps
module cpu_branch_bit_flag_ops_tb;
    // ****************************************************************
    // Signals and bench state
    // ****************************************************************
    logic             ref_clk;
    logic             resetn;
    cbf_pkg::cbf_op_e op;
    logic [6:0]       offset;
    logic [4:0]       reg_sel;
    logic [4:0]       io_sel;
    logic [2:0]       bit_sel;
    logic [15:0]      pc_ff;
    logic [7:0]       status_ff;
    logic             busy_ff;
    logic [7:0]       io_rd_ff;
    logic [7:0]       reg_rd_ff;
    logic [15:0]      exp_pc;
    logic [7:0]       exp_st;
    logic [7:0]       exp_reg;
    int               err_count;
    int               tests_run;
    int               cycle_cnt;

    cbf_exec dut_u (.ref_clk(ref_clk), .resetn(resetn), .op(op), .offset(offset),
        .reg_sel(reg_sel), .io_sel(io_sel), .bit_sel(bit_sel), .pc_ff(pc_ff),
        .status_ff(status_ff), .busy_ff(busy_ff), .io_rd_ff(io_rd_ff), .reg_rd_ff(reg_rd_ff));

    // The clock runs at 10 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Shared checks and drivers
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One op, then a NOP that runs at the next free edge; results are
    // sampled on the falling edge so the launching edge has settled.
    task automatic issue(input cbf_pkg::cbf_op_e o, input logic [6:0] k, input logic [4:0] r,
                         input logic [4:0] p, input logic [2:0] b, input logic two);
        logic [15:0] pc0;
        logic        jump;
        @(posedge ref_clk);
        op <= o;
        offset <= k;
        reg_sel <= r;
        io_sel <= p;
        bit_sel <= b;
        pc0 = exp_pc + 16'h0001;
        jump = two && o != cbf_pkg::CBF_IO_BIT_SET && o != cbf_pkg::CBF_IO_BIT_CLEAR;
        @(posedge ref_clk);
        op <= cbf_pkg::CBF_NOP;
        @(negedge ref_clk);
        chk({15'h0000, busy_ff}, {15'h0000, two});
        if (two) begin
            chk(pc_ff, pc0);
            @(negedge ref_clk);
            chk({15'h0000, busy_ff}, 16'h0000);
        end
        exp_pc = jump ? pc0 + {{9{k[6]}}, k} + 16'h0001 : pc0 + 16'h0001;
        chk(pc_ff, exp_pc);
        chk({8'h00, status_ff}, {8'h00, exp_st});
    endtask

    task automatic do_reset;
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(pc_ff, 16'h0000);
        chk({8'h00, status_ff}, 16'h0000);
        chk({15'h0000, busy_ff}, 16'h0000);
        chk({io_rd_ff, reg_rd_ff}, 16'h0000);
        @(posedge ref_clk);
        resetn <= 1'b1;
        exp_pc = 16'h0000;
        exp_st = 8'h00;
    endtask

    task automatic set_status(input logic [7:0] pat);
        for (int i = 0; i < 8; i++) begin
            exp_st[i] = pat[i];
            issue(pat[i] ? cbf_pkg::CBF_STATUS_BIT_FORCE_ONE : cbf_pkg::CBF_STATUS_BIT_FORCE_ZERO,
                  7'h00, 5'h00, 5'h00, 3'(i), 1'b0);
        end
    endtask

    function automatic logic cond(input cbf_pkg::cbf_op_e o, input logic [7:0] s);
        case (o)
            cbf_pkg::CBF_BRANCH_ON_CARRY_SET:     return s[cbf_pkg::FLAG_C];
            cbf_pkg::CBF_BRANCH_SAME_OR_HIGHER:   return !s[cbf_pkg::FLAG_C];
            cbf_pkg::CBF_BRANCH_ON_CARRY_CLEAR:   return !s[cbf_pkg::FLAG_C];
            cbf_pkg::CBF_BRANCH_ON_NEGATIVE:      return s[cbf_pkg::FLAG_N];
            cbf_pkg::CBF_BRANCH_ON_POSITIVE:      return !s[cbf_pkg::FLAG_N];
            cbf_pkg::CBF_BRANCH_SIGNED_GE:        return !(s[cbf_pkg::FLAG_N] ^ s[cbf_pkg::FLAG_V]);
            cbf_pkg::CBF_BRANCH_SIGNED_LT:        return s[cbf_pkg::FLAG_N] ^ s[cbf_pkg::FLAG_V];
            cbf_pkg::CBF_BRANCH_HALF_CARRY_SET:   return s[cbf_pkg::FLAG_H];
            cbf_pkg::CBF_BRANCH_HALF_CARRY_CLEAR: return !s[cbf_pkg::FLAG_H];
            cbf_pkg::CBF_BRANCH_TRANSFER_BIT_SET: return s[cbf_pkg::FLAG_T];
            cbf_pkg::CBF_BRANCH_IRQ_ENABLED:      return s[cbf_pkg::FLAG_I];
            cbf_pkg::CBF_BRANCH_IRQ_DISABLED:     return !s[cbf_pkg::FLAG_I];
            default:                              return 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Every branch under flag patterns that make it both taken and not,
    // with the most negative displacement on odd op codes, the most positive on even.
    task automatic t_branch;
        logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h04, 8'h08};
        cbf_pkg::cbf_op_e o;
        foreach (pats[j]) begin
            set_status(pats[j]);
            for (int i = 1; i <= 12; i++) begin
                o = cbf_pkg::cbf_op_e'(i);
                issue(o, i[0] ? 7'h40 : 7'h3f, 5'h00, 5'h00, 3'h0, cond(o, exp_st));
            end
        end
    endtask

    task automatic t_io;
        issue(cbf_pkg::CBF_IO_BIT_SET, 7'h00, 5'h00, 5'h03, 3'h5, 1'b1);
        chk({8'h00, io_rd_ff}, 16'h0020);
        issue(cbf_pkg::CBF_IO_BIT_SET, 7'h00, 5'h00, 5'h03, 3'h0, 1'b1);
        chk({8'h00, io_rd_ff}, 16'h0021);
        issue(cbf_pkg::CBF_IO_BIT_CLEAR, 7'h00, 5'h00, 5'h03, 3'h5, 1'b1);
        chk({8'h00, io_rd_ff}, 16'h0001);
    endtask

    // Builds a register value through the transfer flag, then reads it back.
    task automatic t_bits;
        logic [7:0] v = 8'h96;
        exp_reg = 8'h00;
        for (int b = 0; b < 8; b++) begin
            exp_st[cbf_pkg::FLAG_T] = v[b];
            issue(v[b] ? cbf_pkg::CBF_STATUS_BIT_FORCE_ONE : cbf_pkg::CBF_STATUS_BIT_FORCE_ZERO,
                  7'h00, 5'h04, 5'h00, 3'(cbf_pkg::FLAG_T), 1'b0);
            exp_reg[b] = v[b];
            issue(cbf_pkg::CBF_TRANSFER_TO_BIT, 7'h00, 5'h04, 5'h00, 3'(b), 1'b0);
            chk({8'h00, reg_rd_ff}, {8'h00, exp_reg});
        end
        for (int b = 7; b >= 0; b--) begin
            exp_st[cbf_pkg::FLAG_T] = exp_reg[b];
            issue(cbf_pkg::CBF_BIT_TO_TRANSFER, 7'h00, 5'h04, 5'h00, 3'(b), 1'b0);
            chk({8'h00, reg_rd_ff}, {8'h00, exp_reg});
        end
    endtask

    task automatic shift_one(input cbf_pkg::cbf_op_e o, input logic cin);
        logic [7:0] r;
        logic       c;
        exp_st[cbf_pkg::FLAG_C] = cin;
        issue(cin ? cbf_pkg::CBF_STATUS_BIT_FORCE_ONE : cbf_pkg::CBF_STATUS_BIT_FORCE_ZERO,
              7'h00, 5'h04, 5'h00, 3'(cbf_pkg::FLAG_C), 1'b0);
        case (o)
            cbf_pkg::CBF_LOGICAL_LEFT_SHIFT:  {c, r} = {exp_reg, 1'b0};
            cbf_pkg::CBF_LOGICAL_RIGHT_SHIFT: {r, c} = {1'b0, exp_reg};
            cbf_pkg::CBF_ROTATE_LEFT_CARRY:   {c, r} = {exp_reg, cin};
            cbf_pkg::CBF_ROTATE_RIGHT_CARRY:  {r, c} = {cin, exp_reg};
            default:                          {c, r} = {cin, exp_reg[3:0], exp_reg[7:4]};
        endcase
        if (o != cbf_pkg::CBF_NIBBLE_SWAP) begin
            exp_st[cbf_pkg::FLAG_C] = c;
            exp_st[cbf_pkg::FLAG_Z] = (r == 8'h00);
            exp_st[cbf_pkg::FLAG_N] = r[7];
            exp_st[cbf_pkg::FLAG_V] = r[7] ^ c;
        end
        exp_reg = r;
        issue(o, 7'h00, 5'h04, 5'h00, 3'h0, 1'b0);
        chk({8'h00, reg_rd_ff}, {8'h00, exp_reg});
    endtask

    // Shifts continue from the value left by t_bits; the final run of
    // left shifts drives the register to zero so the zero flag is seen.
    task automatic t_shift;
        shift_one(cbf_pkg::CBF_LOGICAL_LEFT_SHIFT, 1'b1);
        shift_one(cbf_pkg::CBF_LOGICAL_RIGHT_SHIFT, 1'b1);
        shift_one(cbf_pkg::CBF_ROTATE_LEFT_CARRY, 1'b1);
        shift_one(cbf_pkg::CBF_ROTATE_RIGHT_CARRY, 1'b1);
        shift_one(cbf_pkg::CBF_ROTATE_RIGHT_CARRY, 1'b0);
        shift_one(cbf_pkg::CBF_NIBBLE_SWAP, 1'b1);
        repeat (8) shift_one(cbf_pkg::CBF_LOGICAL_LEFT_SHIFT, 1'b0);
    endtask

    // ****************************************************************
    // Verdict, hang guard and main sequence
    // ****************************************************************
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The whole run needs about 350 cycles; the ceiling leaves a wide margin.
    always @(posedge ref_clk) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    // Inputs settle at time zero, then each scenario runs in turn.
    initial begin
        resetn = 1'b0;
        op = cbf_pkg::CBF_NOP;
        {offset, reg_sel, io_sel, bit_sel} = 20'h00000;
        {err_count, tests_run, cycle_cnt} = '0;
        do_reset();
        set_status(8'hff);
        set_status(8'h5a);
        t_branch();
        t_io();
        t_bits();
        t_shift();
        do_reset();
        // After the second reset the interrupt flag is clear and the I/O space empty.
        issue(cbf_pkg::CBF_BRANCH_IRQ_DISABLED, 7'h05, 5'h00, 5'h00, 3'h0, 1'b1);
        issue(cbf_pkg::CBF_IO_BIT_SET, 7'h00, 5'h00, 5'h03, 3'h1, 1'b1);
        chk({8'h00, io_rd_ff}, 16'h0002);
        end_of_test();
    end
endmodule
